// ==== logic/pfim_pkg.sv ====
// Shared constants and types for the PWM fault input mode block
package pfim_pkg;

  // ==========================================================
  // Widths
  localparam int CNT_W = 12;
  localparam int MODE_W = 4;

  // ==========================================================
  // Counter phases, in normal running order
  typedef enum logic [1:0] {
    PH_DEAD_A = 2'b00,
    PH_ON_A = 2'b01,
    PH_DEAD_B = 2'b10,
    PH_ON_B = 2'b11
  } pfim_phase_t;

  localparam pfim_phase_t PHASE_RST = PH_DEAD_A;

  // ==========================================================
  // Fault input mode select codes
  localparam logic [MODE_W-1:0] MODE_NONE = 4'h0;
  localparam logic [MODE_W-1:0] MODE_JUMP_WAIT = 4'h1;
  localparam logic [MODE_W-1:0] MODE_EXEC_WAIT = 4'h2;
  localparam logic [MODE_W-1:0] MODE_EXEC_REPEAT = 4'h3;
  localparam logic [MODE_W-1:0] MODE_ALL_OFF = 4'h4;
  localparam logic [MODE_W-1:0] MODE_DEAD_ONLY = 4'h5;
  localparam logic [MODE_W-1:0] MODE_DEAD_WAIT = 4'h6;
  localparam logic [MODE_W-1:0] MODE_SW_WAIT = 4'h7;
  localparam logic [MODE_W-1:0] MODE_EDGE_JUMP = 4'h8;
  localparam logic [MODE_W-1:0] MODE_EDGE_BLANK = 4'h9;
  localparam logic [MODE_W-1:0] MODE_LEVEL_BLANK = 4'hA;

  // ==========================================================
  // Reset values and timing
  localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
  localparam int PRESC_DEF = 1;

  // ==========================================================
  // Phase lengths (a phase lasts length + 1 counter ticks)
  typedef struct packed {
    logic [CNT_W-1:0] dead_a;
    logic [CNT_W-1:0] on_a;
    logic [CNT_W-1:0] dead_b;
    logic [CNT_W-1:0] on_b;
  } pfim_len_t;

  // Mode selection for the two event inputs
  typedef struct packed {
    logic [MODE_W-1:0] mode_b;
    logic [MODE_W-1:0] mode_a;
  } pfim_mode_t;

endpackage

// ==== logic/pfim_top.sv ====
// PWM timer phase sequencer with fault input mode handling
// Function
// R01: Mode 1: event kills output, jumps to opposite dead-time, holds until low.
// R02: Mode 1 input A acts in dead/on-time A, kills A, resumes dead-time B.
// R03: Mode 1 input B acts in dead/on-time B, kills B, resumes dead-time A.
// R04: Mode 2: event kills output, runs opposite phases, then holds while high.
// R05: Mode 2: event gone before opposite phases end means no hold.
// R06: Mode 3: event kills output, opposite phases repeat while fault stays.
// R07: Mode 3: on release current phase finishes, then normal order.
// R08: Modes 4 to 7 act the same for both inputs, on both outputs.
// R09: Mode 4: both outputs off while event, counter runs unchanged.
// R10: Mode 5: on-time event jumps to opposite dead; dead-times alternate.
// R11: Mode 5: after release finish dead-time, then next on-time.
// R12: Mode 6: on-time event jumps to dead-time; counter waits at its end.
// R13: Mode 6: on release the next dead-time starts, normal order.
// R14: Mode 7: event stops outputs and counter until restart command.
// R15: Mode 7: restart with event high stops again, else starts dead-time A.
// R16: Mode 8: rising edge in own on-time jumps to opposite dead-time.
// R17: Mode 9: rising edge in own on-time blanks output for rest of it.
// R18: Mode 10: output off while event; release in on-time keeps it off.
// R19: Software should weigh conflicts when both inputs use different modes.
// R20: Mode 0: inputs leave outputs and counter untouched.
// R21: Software avoids modes 2,3,5,6 in one ramp; dual slope only 0,4,7.
// R22: Mode codes above 10 take no action.
module pfim_top #(
  parameter int PRESC = pfim_pkg::PRESC_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic timer_enable,
  input wire logic restart_cmd,
  input wire logic [1:0] fault_event,
  input wire pfim_pkg::pfim_mode_t fault_input_mode_sel,
  input wire pfim_pkg::pfim_len_t phase_len,
  output logic waveform_out_a,
  output logic waveform_out_b,
  output pfim_pkg::pfim_phase_t phase_state,
  output logic counter_held
);

  // ==========================================================
  // Elaboration checks
  if (PRESC < 1 || PRESC > 4096) begin : g_bad_presc
    $error("PRESC must lie between 1 and 4096");
  end

  // ==========================================================
  // Counter clock divider
  localparam int DIV_W = (PRESC > 1) ? $clog2(PRESC) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PRESC - 1);
  logic [DIV_W-1:0] div_q, div_d;
  logic tick;

  // Divider wraps at the prescale value and yields a one-cycle tick
  always_comb begin
    tick = (div_q == DIV_LAST);
    div_d = tick ? '0 : div_q + DIV_W'(1);
    if (!timer_enable) begin
      div_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // ==========================================================
  // Sequencer state
  pfim_pkg::pfim_phase_t phase_q, phase_d;
  pfim_pkg::pfim_phase_t resume_q, resume_d;
  logic [pfim_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic hold_q, hold_d;
  logic hold_sw_q, hold_sw_d;
  logic hold_src_q, hold_src_d;
  logic [1:0] exec_q, exec_d;
  logic [1:0] blank_q, blank_d;
  logic [1:0] ev_q;
  logic woa_d, wob_d;

  logic [pfim_pkg::MODE_W-1:0] mode [2];
  logic [1:0] rise;
  logic [pfim_pkg::CNT_W-1:0] cur_len;
  logic [1:0] cur, nat_next;
  logic end_now, release_now, kill_all, sw_ev, trig;
  logic [1:0] own_dead, own_on, opp_dead, opp_on, kill;

  assign mode[0] = fault_input_mode_sel.mode_a;
  assign mode[1] = fault_input_mode_sel.mode_b;
  assign rise = fault_event & ~ev_q;

  // Length of the phase in progress
  always_comb begin
    unique case (phase_q)
      pfim_pkg::PH_DEAD_A: cur_len = phase_len.dead_a;
      pfim_pkg::PH_ON_A: cur_len = phase_len.on_a;
      pfim_pkg::PH_DEAD_B: cur_len = phase_len.dead_b;
      pfim_pkg::PH_ON_B: cur_len = phase_len.on_b;
    endcase
  end

  // Next phase, counter, hold and blanking. Input B is handled first so
  // that input A overrides it when both act in one cycle; the two inputs
  // share one counter, so conflicting mode choices are software's concern.
  always_comb begin
    phase_d = phase_q;
    resume_d = resume_q;
    cnt_d = cnt_q;
    hold_d = hold_q;
    hold_sw_d = hold_sw_q;
    hold_src_d = hold_src_q;
    exec_d = exec_q;
    blank_d = blank_q;
    cur = phase_q;
    nat_next = cur + 2'b01;
    end_now = tick && (cnt_q >= cur_len);
    trig = 1'b0;
    sw_ev = 1'b0;
    own_dead = 2'b00;
    own_on = 2'b00;
    opp_dead = 2'b00;
    opp_on = 2'b00;
    for (int x = 0; x < 2; x++) begin
      if (fault_event[x] && mode[x] == pfim_pkg::MODE_SW_WAIT) begin
        sw_ev = 1'b1;
      end
    end
    release_now = hold_sw_q ? (restart_cmd && !sw_ev) // R15
                            : !fault_event[hold_src_q];
    if (!timer_enable) begin
      phase_d = pfim_pkg::PHASE_RST;
      cnt_d = pfim_pkg::CNT_RST;
      hold_d = 1'b0;
      hold_sw_d = 1'b0;
      exec_d = 2'b00;
    end else if (hold_q) begin
      // Counter frozen; release restarts the resume phase from zero
      if (release_now) begin
        hold_d = 1'b0;
        hold_sw_d = 1'b0;
        phase_d = resume_q; // R01 R13
        cnt_d = pfim_pkg::CNT_RST;
      end
    end else begin
      if (end_now) begin
        phase_d = pfim_pkg::pfim_phase_t'(nat_next);
        cnt_d = pfim_pkg::CNT_RST;
      end else if (tick) begin
        cnt_d = cnt_q + 12'h001;
      end
      for (int x = 1; x >= 0; x--) begin
        own_dead = {x[0], 1'b0};
        own_on = {x[0], 1'b1};
        opp_dead = {~x[0], 1'b0};
        opp_on = {~x[0], 1'b1};
        // End-of-phase redirections
        if (end_now) begin
          if (mode[x] == pfim_pkg::MODE_EXEC_WAIT && exec_q[x] &&
              cur == opp_on) begin
            exec_d[x] = 1'b0; // R05
            if (fault_event[x]) begin
              hold_d = 1'b1; // R04
              hold_sw_d = 1'b0;
              hold_src_d = x[0];
              resume_d = pfim_pkg::pfim_phase_t'(nat_next);
            end
          end
          if (mode[x] == pfim_pkg::MODE_EXEC_REPEAT && fault_event[x] &&
              cur == opp_on) begin
            phase_d = pfim_pkg::pfim_phase_t'(opp_dead); // R06 R07
          end
          if (mode[x] == pfim_pkg::MODE_DEAD_ONLY && fault_event[x] &&
              !cur[0]) begin
            phase_d = pfim_pkg::pfim_phase_t'({~cur[1], 1'b0}); // R10 R11
          end
          if (mode[x] == pfim_pkg::MODE_DEAD_WAIT && fault_event[x] &&
              !cur[0]) begin
            hold_d = 1'b1; // R12
            hold_sw_d = 1'b0;
            hold_src_d = x[0];
            resume_d = pfim_pkg::pfim_phase_t'({~cur[1], 1'b0}); // R13
            // Wait at the end of the dead-time, never inside the on-time
            phase_d = phase_q; // R12
          end
        end
        // Fault triggers, which override the end-of-phase result
        trig = 1'b0;
        unique case (mode[x])
          pfim_pkg::MODE_JUMP_WAIT: begin
            if (fault_event[x] && cur[1] == x[0]) begin
              trig = 1'b1; // R02 R03
              hold_d = 1'b1; // R01
              hold_sw_d = 1'b0;
              hold_src_d = x[0];
              resume_d = pfim_pkg::pfim_phase_t'(opp_dead);
            end
          end
          pfim_pkg::MODE_EXEC_WAIT: begin
            if (fault_event[x] && cur[1] == x[0]) begin
              trig = 1'b1; // R04
              exec_d[x] = 1'b1;
            end
          end
          pfim_pkg::MODE_EXEC_REPEAT: begin
            trig = fault_event[x] && cur[1] == x[0]; // R06
          end
          pfim_pkg::MODE_DEAD_ONLY, pfim_pkg::MODE_DEAD_WAIT: begin
            if (fault_event[x] && cur[0]) begin
              trig = 1'b1; // R08 R10 R12
              opp_dead = {~cur[1], 1'b0};
            end
          end
          pfim_pkg::MODE_SW_WAIT: begin
            if (fault_event[x]) begin
              hold_d = 1'b1; // R08 R14
              hold_sw_d = 1'b1;
              resume_d = pfim_pkg::PH_DEAD_A; // R15
            end
          end
          pfim_pkg::MODE_EDGE_JUMP: begin
            trig = rise[x] && cur == own_on; // R16
          end
          default: begin
            trig = 1'b0; // R20 R22
          end
        endcase
        if (trig) begin
          phase_d = pfim_pkg::pfim_phase_t'(opp_dead);
          cnt_d = pfim_pkg::CNT_RST;
        end
      end
    end
    // Output blanking lasts until the own on-time is left
    for (int x = 0; x < 2; x++) begin
      own_on = {x[0], 1'b1};
      if (phase_d != own_on || phase_d != phase_q || cnt_d != cnt_q &&
          cnt_d == pfim_pkg::CNT_RST) begin
        blank_d[x] = 1'b0;
      end
      if (phase_d == own_on && phase_q == own_on) begin
        if (mode[x] == pfim_pkg::MODE_EDGE_BLANK && rise[x]) begin
          blank_d[x] = 1'b1; // R17
        end
        if (mode[x] == pfim_pkg::MODE_LEVEL_BLANK && fault_event[x]) begin
          blank_d[x] = 1'b1; // R18
        end
      end
    end
  end

  // Output kill terms; output regs see the phase being entered
  always_comb begin
    kill_all = hold_d;
    for (int x = 0; x < 2; x++) begin
      if (fault_event[x] && (mode[x] == pfim_pkg::MODE_ALL_OFF ||
          mode[x] == pfim_pkg::MODE_DEAD_ONLY)) begin
        kill_all = 1'b1; // R08 R09
      end
      kill[x] = blank_d[x] ||
                (fault_event[x] && mode[x] == pfim_pkg::MODE_LEVEL_BLANK);
    end
    woa_d = timer_enable && phase_d == pfim_pkg::PH_ON_A && !kill_all &&
            !kill[0];
    wob_d = timer_enable && phase_d == pfim_pkg::PH_ON_B && !kill_all &&
            !kill[1];
  end

  // Registers only; all outputs come straight from here
  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase_q <= pfim_pkg::PHASE_RST;
      resume_q <= pfim_pkg::PHASE_RST;
      cnt_q <= pfim_pkg::CNT_RST;
      hold_q <= 1'b0;
      hold_sw_q <= 1'b0;
      hold_src_q <= 1'b0;
      exec_q <= 2'b00;
      blank_q <= 2'b00;
      ev_q <= 2'b00;
      waveform_out_a <= 1'b0;
      waveform_out_b <= 1'b0;
      phase_state <= pfim_pkg::PHASE_RST;
      counter_held <= 1'b0;
    end else begin
      phase_q <= phase_d;
      resume_q <= resume_d;
      cnt_q <= cnt_d;
      hold_q <= hold_d;
      hold_sw_q <= hold_sw_d;
      hold_src_q <= hold_src_d;
      exec_q <= exec_d;
      blank_q <= blank_d;
      ev_q <= fault_event;
      waveform_out_a <= woa_d;
      waveform_out_b <= wob_d;
      phase_state <= phase_d;
      counter_held <= hold_d;
    end
  end

endmodule

// ==== sim/pfim_evt_net.sv ====
// Event routing network model delivering fault levels to the block
module pfim_evt_net (
  input wire logic clk,
  input wire logic [1:0] evt_req,
  output logic [1:0] fault_event
);
  timeunit 1ns;
  timeprecision 1ps;
  // One routing stage, so a request shows a cycle late, never early
  initial fault_event = 2'h0;
  always @(negedge clk) begin
    fault_event <= evt_req;
  end
endmodule

// ==== sim/pfim_sva.sv ====
// Concurrent checks on the fault input mode sequencer ports
module pfim_sva #(
  parameter int PRESC = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic timer_enable,
  input wire logic restart_cmd,
  input wire logic [1:0] fault_event,
  input wire pfim_pkg::pfim_mode_t fault_input_mode_sel,
  input wire pfim_pkg::pfim_len_t phase_len,
  input wire logic waveform_out_a,
  input wire logic waveform_out_b,
  input wire pfim_pkg::pfim_phase_t phase_state,
  input wire logic counter_held
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // Decode shared by the properties
  logic [3:0] ma;
  logic [3:0] mb;
  logic run;
  assign ma = fault_input_mode_sel.mode_a;
  assign mb = fault_input_mode_sel.mode_b;
  assign run = timer_enable && !counter_held;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Mode 7 hold and a restart that should release it
  sequence s_m7_hold;
    ma == 4'h7 && mb == 4'h7 && counter_held && timer_enable;
  endsequence
  sequence s_clean_restart;
    restart_cmd && fault_event == 2'h0;
  endsequence

  // ============================================================
  // Properties
  a_reset_idle: assert property (disable iff (1'b0) !resetn |=>
    phase_state == pfim_pkg::PH_DEAD_A && !counter_held
    && !waveform_out_a && !waveform_out_b) else $error("reset not idle");
  a_out_a_phase: assert property (
    waveform_out_a |-> phase_state == pfim_pkg::PH_ON_A)
    else $error("out a high outside on-time a");
  a_hold_kills: assert property (
    counter_held |-> !waveform_out_a && !waveform_out_b)
    else $error("output on while held");
  a_m1_jump: assert property (
    run && ma == 4'h1 && mb == 4'h0 && fault_event[0]
    && phase_state == pfim_pkg::PH_ON_A |=> counter_held
    && phase_state == pfim_pkg::PH_DEAD_B && !waveform_out_a)
    else $error("mode 1 jump wrong");
  a_m1_release: assert property (
    counter_held && timer_enable && ma == 4'h1 && mb == 4'h0
    && !fault_event[0] |=> !counter_held) else $error("mode 1 no release");
  a_m4_runs: assert property (
    run && ma == 4'h4 && mb == 4'h4 |=> !counter_held)
    else $error("mode 4 held counter");
  a_m4_dark: assert property (
    timer_enable && ma == 4'h4 && fault_event[0] |=>
    !waveform_out_a && !waveform_out_b) else $error("mode 4 output on");
  a_m7_stays: assert property (
    s_m7_hold ##0 !(restart_cmd && fault_event == 2'h0) |=> counter_held)
    else $error("mode 7 hold lost");
  a_m7_restart: assert property (
    s_m7_hold ##0 s_clean_restart |=> !counter_held
    && phase_state == pfim_pkg::PH_DEAD_A) else $error("bad restart");
  a_m9_edge: assert property (
    timer_enable && ma == 4'h9 && $rose(fault_event[0])
    && phase_state == pfim_pkg::PH_ON_A |=> !waveform_out_a [*3])
    else $error("mode 9 not blanked");
  a_m10_level: assert property (
    timer_enable && ma == 4'hA && fault_event[0] |=> !waveform_out_a)
    else $error("mode 10 output on");
  a_idle_modes: assert property (
    run && (ma == 4'h0 || ma > 4'hA) && (mb == 4'h0 || mb > 4'hA)
    |=> !counter_held) else $error("idle mode held counter");
  a_phase_order: assert property (
    (run && ma == 4'h0 && mb == 4'h0 && phase_state == pfim_pkg::PH_ON_A)
    ##1 phase_state != pfim_pkg::PH_ON_A
    |-> phase_state == pfim_pkg::PH_DEAD_B) else $error("phase order");
endmodule

bind pfim_top pfim_sva #(.PRESC(PRESC)) sva_u (.clk(clk), .resetn(resetn),
  .timer_enable(timer_enable), .restart_cmd(restart_cmd),
  .fault_event(fault_event), .fault_input_mode_sel(fault_input_mode_sel),
  .phase_len(phase_len), .waveform_out_a(waveform_out_a),
  .waveform_out_b(waveform_out_b), .phase_state(phase_state),
  .counter_held(counter_held));

// ==== sim/test_pwm_fault_input_modes.sv ====
// Self-checking bench for the fault input mode sequencer
module test_pwm_fault_input_modes;
  timeunit 1ns;
  timeprecision 1ps;
  // Local aliases of the shared types and phase codes
  typedef pfim_pkg::pfim_mode_t pfim_mode_t;
  typedef pfim_pkg::pfim_len_t pfim_len_t;
  typedef pfim_pkg::pfim_phase_t pfim_phase_t;
  localparam pfim_phase_t PH_DEAD_A = pfim_pkg::PH_DEAD_A;
  localparam pfim_phase_t PH_ON_A = pfim_pkg::PH_ON_A;
  localparam pfim_phase_t PH_DEAD_B = pfim_pkg::PH_DEAD_B;
  localparam pfim_phase_t PH_ON_B = pfim_pkg::PH_ON_B;
  logic clk;
  logic resetn;
  logic timer_enable;
  logic restart_cmd;
  logic [1:0] evt_req;
  logic [1:0] fault_event;
  pfim_mode_t modes;
  pfim_len_t lens;
  logic wo_a;
  logic wo_b;
  pfim_phase_t phase;
  logic held;
  int failures;
  int tests_run;

  pfim_top #(.PRESC(1)) dut_u (.clk(clk), .resetn(resetn),
    .timer_enable(timer_enable), .restart_cmd(restart_cmd),
    .fault_event(fault_event), .fault_input_mode_sel(modes),
    .phase_len(lens), .waveform_out_a(wo_a), .waveform_out_b(wo_b),
    .phase_state(phase), .counter_held(held));
  pfim_evt_net ev_u (.clk(clk), .evt_req(evt_req), .fault_event(fault_event));

  // ============================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded waits, so a stuck counter shows as a mismatch
  task automatic wait_ph(input pfim_phase_t p);
    int n;
    n = 0;
    while (phase !== p && n < 100) begin
      tick(1);
      n++;
    end
  endtask
  task automatic nxt;
    pfim_phase_t p;
    int n;
    p = phase;
    n = 0;
    while (phase === p && n < 100) begin
      tick(1);
      n++;
    end
  endtask
  // Restart the counter cleanly in a new mode pair
  task automatic setup(input logic [7:0] m);
    evt_req <= 2'h0;
    modes = m;
    timer_enable = 0;
    tick(2);
    timer_enable = 1;
  endtask
  task automatic fin(input string s);
    $display("%s done, %0d mismatches", s, failures);
  endtask
  task automatic summarize;
    $display("Counts: %0d compared, %0d mismatched", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ============================================================
  // Scenarios
  task automatic t_idle(input logic [7:0] m);
    setup(m);
    evt_req <= 2'h3;
    wait_ph(PH_ON_A);
    tick(1);
    chk(wo_a, 1);
    nxt;
    chk(phase, PH_DEAD_B);
    nxt;
    chk({phase, wo_b, held}, {PH_ON_B, 2'b10});
    fin("idle");
  endtask
  task automatic t_m1(input int i);
    pfim_phase_t opp;
    opp = i ? PH_DEAD_A : PH_DEAD_B;
    setup(i ? 8'h10 : 8'h01);
    wait_ph(i ? PH_ON_B : PH_ON_A);
    evt_req <= 2'h1 << i;
    nxt;
    chk({phase, held, i ? wo_b : wo_a}, {opp, 2'b10});
    tick(8);
    chk({phase, held}, {opp, 1'b1});
    evt_req <= 2'h0;
    tick(3);
    chk(held, 0);
    nxt;
    chk(phase, i ? PH_ON_A : PH_ON_B);
    fin("mode 1");
  endtask
  task automatic t_m2(input logic early);
    setup(8'h02);
    wait_ph(PH_ON_A);
    evt_req <= 2'h1;
    nxt;
    chk(phase, PH_DEAD_B);
    if (early) evt_req <= 2'h0;
    nxt;
    chk(phase, PH_ON_B);
    if (!early) begin
      tick(8);
      chk(held, 1);
    end
    evt_req <= 2'h0;
    // A mode 2 hold already shows dead-time A, so count edges instead
    if (early) begin
      nxt;
    end else begin
      tick(3);
    end
    chk({phase, held}, {PH_DEAD_A, 1'b0});
    fin("mode 2");
  endtask
  task automatic t_m4;
    setup(8'h44);
    wait_ph(PH_ON_A);
    evt_req <= 2'h2;
    tick(2);
    chk({wo_a, wo_b}, 2'b00);
    nxt;
    chk({phase, held}, {PH_DEAD_B, 1'b0});
    evt_req <= 2'h0;
    wait_ph(PH_ON_A);
    tick(1);
    chk(wo_a, 1);
    fin("mode 4");
  endtask
  task automatic t_m6;
    setup(8'h66);
    wait_ph(PH_ON_A);
    evt_req <= 2'h1;
    nxt;
    chk(phase, PH_DEAD_B);
    tick(10);
    chk({phase, held}, {PH_DEAD_B, 1'b1});
    evt_req <= 2'h0;
    nxt;
    chk(phase, PH_DEAD_A);
    fin("mode 6");
  endtask
  task automatic t_m3;
    setup(8'h03);
    wait_ph(PH_ON_A);
    evt_req <= 2'h1;
    nxt;
    chk({phase, wo_a}, {PH_DEAD_B, 1'b0});
    nxt;
    chk({phase, wo_b}, {PH_ON_B, 1'b1});
    nxt;
    chk(phase, PH_DEAD_B);
    evt_req <= 2'h0;
    nxt;
    chk(phase, PH_ON_B);
    nxt;
    chk(phase, PH_DEAD_A);
    fin("mode 3");
  endtask
  task automatic t_m5;
    setup(8'h55);
    wait_ph(PH_ON_A);
    evt_req <= 2'h2;
    nxt;
    chk({phase, wo_a, wo_b}, {PH_DEAD_B, 2'b00});
    nxt;
    chk({phase, held}, {PH_DEAD_A, 1'b0});
    evt_req <= 2'h0;
    nxt;
    chk({phase, wo_a}, {PH_ON_A, 1'b1});
    fin("mode 5");
  endtask
  task automatic t_m7;
    pfim_phase_t p;
    setup(8'h77);
    wait_ph(PH_ON_B);
    evt_req <= 2'h1;
    tick(3);
    p = phase;
    chk({held, wo_a, wo_b}, 3'b100);
    tick(6);
    chk({phase, held}, {p, 1'b1});
    restart_cmd = 1;
    tick(1);
    restart_cmd = 0;
    tick(1);
    chk(held, 1);
    evt_req <= 2'h0;
    tick(2);
    restart_cmd = 1;
    tick(1);
    restart_cmd = 0;
    chk({held, phase}, {1'b0, PH_DEAD_A});
    fin("mode 7");
  endtask
  task automatic t_edge(input logic [3:0] m);
    setup({4'h0, m});
    wait_ph(PH_ON_A);
    evt_req <= 2'h1;
    tick(2);
    chk({wo_a, phase}, {1'b0, m == 4'h8 ? PH_DEAD_B : PH_ON_A});
    tick(1);
    chk(wo_a, 0);
    evt_req <= 2'h0;
    wait_ph(PH_ON_B);
    wait_ph(PH_ON_A);
    tick(1);
    chk(wo_a, 1);
    fin("edge mode");
  endtask
  task automatic t_m10;
    setup(8'h0A);
    evt_req <= 2'h1;
    wait_ph(PH_ON_A);
    tick(1);
    chk(wo_a, 0);
    evt_req <= 2'h0;
    tick(2);
    chk({phase, wo_a}, {PH_ON_A, 1'b0});
    wait_ph(PH_ON_B);
    wait_ph(PH_ON_A);
    tick(1);
    chk(wo_a, 1);
    fin("mode 10");
  endtask

  // ============================================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    failures++;
    summarize;
  end
  initial begin
    resetn = 0;
    timer_enable = 0;
    restart_cmd = 0;
    evt_req = 2'h0;
    modes = 8'h00;
    lens = 48'h004004004004;
    failures = 0;
    tests_run = 0;
    tick(6);
    resetn = 1;
    t_idle(8'h00);
    t_idle(8'hBF);
    t_m1(0);
    t_m1(1);
    t_m2(0);
    t_m2(1);
    t_m4;
    t_m6;
    t_m3;
    t_m5;
    t_m7;
    t_edge(4'h8);
    t_edge(4'h9);
    t_m10;
    summarize;
  end
endmodule
